/* flash_seq_pkg.sv */
// constants and carriers for the flash program/erase sequencer (host end)
// assumes a 20 MHz system clock and an AXI4-Lite master for software
// How it works
// [R01] flash is programmed 32 bytes per program pulse, never fewer
// [R02] a program group starts at a low address byte multiple of 0x20
// [R03] wait at least x us after write enable before sending program data
// [R04] flash latches address and data over 32 consecutive byte writes
// [R05] unused bytes of a group are written as 0xff
// [R06] watchdog runs before program setup, longer than y+z+alpha+beta
// [R07] set program setup, wait at least y us, then set program bit
// [R08] program pulse at most z us, length depends on loop count
// [R09] clear program bit, wait alpha, clear setup, stop watchdog
// [R10] program-verify: wait gamma, dummy write 0xff before each read
// [R11] verify read returns the latched word; wait epsilon after dummy write
// [R12] reprogram data is computed from verify data, kept apart
// [R13] after 32 bytes verified, leave verify, wait eta, finish or loop
// [R14] program and verify loop runs at most N times
// [R15] erase one block; block select at least x us after write enable
// [R16] watchdog runs before erase setup, longer than z ms plus waits
// [R17] set erase setup, wait at least y us, then set erase bit
// [R18] erase pulse at most z ms
// [R19] erase needs no preprogramming of the block to zeros
// [R20] clear erase, wait alpha, clear setup, stop watchdog, set verify
// [R21] erase-verify: dummy write, read; all ones moves on, else re-erase
// [R22] erase and verify loop runs at most N times
// [R23] flash array is unreadable during program or erase
// [R24] no program or erase while the write enable pin is low
// [R25] program or erase mode needs its setup bit set beforehand
package flash_seq_pkg;
	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned CYC_PER_US = CLK_MHZ;
	localparam int unsigned US_PER_MS = 1000;

	// own register map (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_ADDR = 8'h08;
	localparam logic [7:0] OFF_BLOCK = 8'h0c;
	localparam logic [7:0] OFF_ELEN = 8'h10;
	localparam logic [7:0] OFF_DATA = 8'h20;
	localparam logic [2:0] DATA_WORDS_HI = 3'h7;
	// control fields
	localparam int CTRL_START = 0;
	localparam int CTRL_ERASE = 1;
	localparam int CTRL_WE = 2;
	// status fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_FAIL = 2;
	localparam int STAT_LOOP = 8;
	localparam int STAT_STATE = 16;

	// device control image bit positions
	localparam int FC_WRITE = 0;
	localparam int FC_CLEAR = 1;
	localparam int FC_WRITE_VERIFY = 2;
	localparam int FC_CLEAR_VERIFY = 3;
	localparam int FC_WRITE_SETUP = 4;
	localparam int FC_CLEAR_SETUP = 5;
	localparam int FC_SW_ENABLE = 6;

	localparam int unsigned GROUP_BYTES = 32;
	localparam logic [7:0] FILL_BYTE = 8'hff;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [31:0] RESP_OKAY = 32'h0;

	typedef enum logic [1:0] {
		DEV_CTRL = 2'h0,
		DEV_BLOCK = 2'h1,
		DEV_WRITE = 2'h2,
		DEV_READ = 2'h3
	} dev_kind_t;

	typedef struct packed {
		logic valid;
		dev_kind_t kind;
		logic [19:0] addr;
		logic [15:0] data;
	} dev_req_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	function automatic logic [31:0] us_to_cyc(input int unsigned us);
		logic [31:0] c;
		c = 32'(us * CYC_PER_US);
		return (c == 32'h0) ? 32'h1 : c;
	endfunction : us_to_cyc
endpackage : flash_seq_pkg

/* flash_program_erase_sequencer.sv */
// host sequencer: walks the flash through program/verify and erase/verify
// assumes the flash takes one request per valid cycle and answers reads
// later with dev_rvalid_i; software loads data and orders over AXI4-Lite
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module flash_program_erase_sequencer #(
	parameter int unsigned T_X_US = 10,
	parameter int unsigned T_Y_US = 50,
	parameter int unsigned T_Z_US = 30,
	parameter int unsigned T_Z_LONG_US = 200,
	parameter int unsigned LOOPS_SHORT = 6,
	parameter int unsigned T_ZE_MS = 10,
	parameter int unsigned T_ALPHA_US = 10,
	parameter int unsigned T_BETA_US = 10,
	parameter int unsigned T_GAMMA_US = 20,
	parameter int unsigned T_EPS_US = 2,
	parameter int unsigned T_ETA_US = 100,
	parameter logic [7:0] MAX_LOOPS = 8'd100
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire flash_seq_pkg::axil_req_t axi_req_i,
	output flash_seq_pkg::axil_rsp_t axi_rsp_o,
	output flash_seq_pkg::dev_req_t dev_req_o,
	input wire logic dev_rvalid_i,
	input wire logic [15:0] dev_rdata_i,
	output logic write_enable_pin_o,
	output logic watchdog_timer_run_o
);
	import flash_seq_pkg::*;

	localparam logic [31:0] CYC_X = us_to_cyc(T_X_US);
	localparam logic [31:0] CYC_Y = us_to_cyc(T_Y_US);
	localparam logic [31:0] CYC_Z = us_to_cyc(T_Z_US);
	localparam logic [31:0] CYC_ZL = us_to_cyc(T_Z_LONG_US);
	localparam logic [31:0] CYC_ZE = us_to_cyc(T_ZE_MS * US_PER_MS);
	localparam logic [31:0] CYC_ALPHA = us_to_cyc(T_ALPHA_US);
	localparam logic [31:0] CYC_BETA = us_to_cyc(T_BETA_US);
	localparam logic [31:0] CYC_GAMMA = us_to_cyc(T_GAMMA_US);
	localparam logic [31:0] CYC_EPS = us_to_cyc(T_EPS_US);
	localparam logic [31:0] CYC_ETA = us_to_cyc(T_ETA_US);

	// ==========================================================
	// state
	typedef enum logic [14:0] {
		ST_IDLE = 15'h0001,
		ST_SWE = 15'h0002,
		ST_BLK = 15'h0004,
		ST_XFER = 15'h0008,
		ST_SETUP = 15'h0010,
		ST_PULSE = 15'h0020,
		ST_UNPULSE = 15'h0040,
		ST_UNSETUP = 15'h0080,
		ST_VERIFY = 15'h0100,
		ST_VDUMMY = 15'h0200,
		ST_VREAD = 15'h0400,
		ST_VRESP = 15'h0800,
		ST_UNVERIFY = 15'h1000,
		ST_FINISH = 15'h2000,
		ST_WAIT = 15'h4000
	} state_t;

	typedef struct packed {
		state_t st;
		state_t ret;
		logic [31:0] wait_cnt;
		logic [15:0] idx;
		logic [7:0] loops;
		logic erase;
		logic need;
		logic done;
		logic fail;
		logic write_enable_pin;
		logic wdt;
		logic [7:0] fctl;
		logic [19:0] base;
		logic [7:0] blocks;
		logic [15:0] elen;
		logic [GROUP_BYTES-1:0][7:0] prog;
		logic [GROUP_BYTES-1:0][7:0] reprog;
		logic aw_have;
		logic [7:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		dev_req_t dev;
		axil_rsp_t rsp;
	} seq_t;

	seq_t r;
	seq_t next_r;

	assign axi_rsp_o = r.rsp;
	assign dev_req_o = r.dev;
	assign write_enable_pin_o = r.write_enable_pin;
	assign watchdog_timer_run_o = r.wdt;

	function automatic seq_t ctl_then_wait(input seq_t s, input logic [7:0] f,
			input logic [31:0] n, input state_t nxt);
		s.fctl = f;
		s.dev.valid = 1'b1;
		s.dev.kind = DEV_CTRL;
		s.dev.data = {8'h00, f};
		s.wait_cnt = n;
		s.ret = nxt;
		s.st = ST_WAIT;
		return s;
	endfunction : ctl_then_wait

	// ==========================================================
	// next state
	always_comb begin
		logic [7:0] f;
		logic [4:0] b;
		logic [7:0] vb;
		logic last;
		f = r.fctl;
		b = 5'h0;
		vb = 8'h00;
		last = 1'b0;
		next_r = r;
		next_r.dev.valid = 1'b0;

		// bus slave: address and data taken in either order
		if (r.rsp.awready && axi_req_i.awvalid) begin
			next_r.aw_have = 1'b1;
			next_r.awaddr = axi_req_i.awaddr;
		end
		if (r.rsp.wready && axi_req_i.wvalid) begin
			next_r.w_have = 1'b1;
			next_r.wdata = axi_req_i.wdata;
			next_r.wstrb = axi_req_i.wstrb;
		end
		if (r.rsp.bvalid && axi_req_i.bready)
			next_r.rsp.bvalid = 1'b0;
		if (next_r.aw_have && next_r.w_have && !r.rsp.bvalid) begin
			next_r.aw_have = 1'b0;
			next_r.w_have = 1'b0;
			next_r.rsp.bvalid = 1'b1;
			next_r.rsp.bresp = 2'h0;
			case (next_r.awaddr)
			OFF_CTRL: begin
				next_r.write_enable_pin = next_r.wdata[CTRL_WE];
				// start only when idle and the enable pin is raised
				if (next_r.wdata[CTRL_START] && r.st == ST_IDLE &&
						r.write_enable_pin) begin // [R24]
					next_r.erase = next_r.wdata[CTRL_ERASE];
					next_r.reprog = r.prog;
					next_r.loops = 8'h00;
					next_r.idx = 16'h0000;
					next_r.need = 1'b0;
					next_r.st = ST_SWE;
				end
			end
			OFF_STATUS: begin
				if (next_r.wdata[STAT_DONE])
					next_r.done = 1'b0;
				if (next_r.wdata[STAT_FAIL])
					next_r.fail = 1'b0;
			end
			OFF_ADDR: next_r.base = {next_r.wdata[19:5], 5'h00}; // [R02]
			OFF_BLOCK: next_r.blocks = next_r.wdata[7:0];
			OFF_ELEN: next_r.elen = next_r.wdata[15:0];
			default: begin
				if (next_r.awaddr[7:5] == OFF_DATA[7:5]) begin
					for (int i = 0; i < 4; i++) begin
						if (next_r.wstrb[i])
							next_r.prog[{next_r.awaddr[4:2], 2'(i)}] =
								next_r.wdata[i*8 +: 8];
					end
				end
			end
			endcase
		end
		next_r.rsp.awready = !next_r.aw_have && !next_r.rsp.bvalid;
		next_r.rsp.wready = !next_r.w_have && !next_r.rsp.bvalid;

		if (r.rsp.rvalid && axi_req_i.rready)
			next_r.rsp.rvalid = 1'b0;
		if (r.rsp.arready && axi_req_i.arvalid) begin
			next_r.rsp.rvalid = 1'b1;
			next_r.rsp.rresp = 2'h0;
			next_r.rsp.rdata = RESP_OKAY;
			case (axi_req_i.araddr)
			OFF_CTRL: next_r.rsp.rdata[CTRL_WE] = r.write_enable_pin;
			OFF_STATUS: begin
				next_r.rsp.rdata[STAT_BUSY] = (r.st != ST_IDLE);
				next_r.rsp.rdata[STAT_DONE] = r.done;
				next_r.rsp.rdata[STAT_FAIL] = r.fail;
				next_r.rsp.rdata[STAT_LOOP +: 8] = r.loops;
				next_r.rsp.rdata[STAT_STATE +: 15] = r.st;
			end
			OFF_ADDR: next_r.rsp.rdata[19:0] = r.base;
			OFF_BLOCK: next_r.rsp.rdata[7:0] = r.blocks;
			OFF_ELEN: next_r.rsp.rdata[15:0] = r.elen;
			default: begin
				if (axi_req_i.araddr[7:5] == OFF_DATA[7:5])
					next_r.rsp.rdata = r.prog[axi_req_i.araddr[4:2] * 4 +: 4];
			end
			endcase
		end
		next_r.rsp.arready = !next_r.rsp.rvalid;

		// ======================================================
		// sequencer
		case (r.st)
		ST_IDLE: begin
		end
		ST_WAIT: begin
			if (r.wait_cnt <= 32'h1)
				next_r.st = r.ret;
			else
				next_r.wait_cnt = r.wait_cnt - 32'h1;
		end
		ST_SWE: begin
			f = 8'h00;
			f[FC_SW_ENABLE] = 1'b1;
			next_r = ctl_then_wait(next_r, f, CYC_X,
				r.erase ? ST_BLK : ST_XFER); // [R03] [R15]
		end
		ST_BLK: begin
			next_r.dev.valid = 1'b1;
			next_r.dev.kind = DEV_BLOCK;
			next_r.dev.data = {8'h00, r.blocks}; // [R15] [R19]
			next_r.st = ST_SETUP;
		end
		ST_XFER: begin
			// whole group every time; unused bytes hold 0xff [R01] [R05]
			b = r.idx[4:0];
			next_r.dev.valid = 1'b1;
			next_r.dev.kind = DEV_WRITE;
			next_r.dev.addr = r.base | {15'h0, b};
			next_r.dev.data = {8'h00, r.reprog[b]}; // [R04]
			next_r.idx = r.idx + 16'h1;
			if (b == 5'h1f) begin
				next_r.idx = 16'h0000;
				next_r.st = ST_SETUP;
			end
		end
		ST_SETUP: begin
			next_r.wdt = 1'b1; // [R06] [R16]
			f[r.erase ? FC_CLEAR_SETUP : FC_WRITE_SETUP] = 1'b1;
			next_r = ctl_then_wait(next_r, f, CYC_Y, ST_PULSE); // [R07] [R17]
		end
		ST_PULSE: begin
			// mode bit only follows its setup bit [R25]
			f[r.erase ? FC_CLEAR : FC_WRITE] = 1'b1;
			next_r = ctl_then_wait(next_r, f,
				r.erase ? CYC_ZE :
				((32'(r.loops) < LOOPS_SHORT) ? CYC_Z : CYC_ZL),
				ST_UNPULSE); // [R08] [R18] [R23]
		end
		ST_UNPULSE: begin
			f[FC_WRITE] = 1'b0;
			f[FC_CLEAR] = 1'b0;
			next_r = ctl_then_wait(next_r, f, CYC_ALPHA,
				ST_UNSETUP); // [R09] [R20]
		end
		ST_UNSETUP: begin
			f[FC_WRITE_SETUP] = 1'b0;
			f[FC_CLEAR_SETUP] = 1'b0;
			next_r.wdt = 1'b0; // [R09] [R20]
			next_r = ctl_then_wait(next_r, f, CYC_BETA, ST_VERIFY);
		end
		ST_VERIFY: begin
			f[r.erase ? FC_CLEAR_VERIFY : FC_WRITE_VERIFY] = 1'b1;
			next_r.idx = 16'h0000;
			next_r.need = 1'b0;
			next_r = ctl_then_wait(next_r, f, CYC_GAMMA,
				ST_VDUMMY); // [R10] [R20] [R21]
		end
		ST_VDUMMY: begin
			next_r.dev.valid = 1'b1;
			next_r.dev.kind = DEV_WRITE;
			next_r.dev.addr = r.base + {r.idx[14:0], 5'h00} / 20'd16;
			next_r.dev.data = {8'h00, FILL_BYTE}; // [R10] [R21]
			next_r.wait_cnt = CYC_EPS; // [R11]
			next_r.ret = ST_VREAD;
			next_r.st = ST_WAIT;
		end
		ST_VREAD: begin
			next_r.dev.valid = 1'b1;
			next_r.dev.kind = DEV_READ;
			next_r.st = ST_VRESP;
		end
		ST_VRESP: begin
			if (dev_rvalid_i) begin // [R11]
				if (r.erase) begin
					last = (r.idx + 16'h1 >= r.elen);
					if (dev_rdata_i != ERASED_WORD) begin // [R21]
						next_r.need = 1'b1;
						last = 1'b1;
					end
				end else begin
					// even byte in the high half of the word
					last = (r.idx[3:0] == 4'hf);
					b = {r.idx[3:0], 1'b0};
					vb = r.prog[b] | ~dev_rdata_i[15:8]; // [R12]
					next_r.reprog[b] = vb;
					if (vb != FILL_BYTE)
						next_r.need = 1'b1;
					vb = r.prog[b | 5'h1] | ~dev_rdata_i[7:0];
					next_r.reprog[b | 5'h1] = vb;
					if (vb != FILL_BYTE)
						next_r.need = 1'b1;
				end
				next_r.idx = r.idx + 16'h1;
				next_r.st = last ? ST_UNVERIFY : ST_VDUMMY;
			end
		end
		ST_UNVERIFY: begin
			f[FC_WRITE_VERIFY] = 1'b0;
			f[FC_CLEAR_VERIFY] = 1'b0;
			next_r = ctl_then_wait(next_r, f, CYC_ETA, ST_FINISH); // [R13]
		end
		ST_FINISH: begin
			next_r.idx = 16'h0000;
			if (r.need && r.loops + 8'h1 < MAX_LOOPS) begin // [R14] [R22]
				next_r.loops = r.loops + 8'h1;
				next_r.st = r.erase ? ST_SETUP : ST_XFER;
			end else begin
				f = 8'h00;
				next_r = ctl_then_wait(next_r, f, 32'h1, ST_IDLE);
				next_r.loops = r.loops + 8'h1;
				// set wins over a clear in the same cycle
				if (r.need)
					next_r.fail = 1'b1;
				else
					next_r.done = 1'b1;
			end
		end
		default: next_r.st = ST_IDLE;
		endcase

		// dropped enable aborts; the device protects itself too [R24]
		if (!next_r.write_enable_pin && r.st != ST_IDLE) begin
			next_r.st = ST_IDLE;
			next_r.fctl = 8'h00;
			next_r.wdt = 1'b0;
			next_r.fail = 1'b1;
		end
		if (r.erase)
			next_r.dev.addr = (r.st == ST_VDUMMY || r.st == ST_VREAD) ?
				r.base + {3'h0, r.idx, 1'b0} : next_r.dev.addr;
		else if (r.st == ST_VDUMMY || r.st == ST_VREAD)
			next_r.dev.addr = r.base | {15'h0, r.idx[3:0], 1'b0};
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			r <= '0;
			// unloaded program bytes stay at the erased level [R05]
			r.prog <= '1;
			r.reprog <= '1;
			r.st <= ST_IDLE;
			r.ret <= ST_IDLE;
		end else begin
			r <= next_r;
		end
	end
endmodule : flash_program_erase_sequencer

/* flash_seq_checker.sv */
// checker: order and timing of the sequencer's device requests and pins
// sees only the top ports; bound to the sequencer after endmodule
`timescale 1ns/1ns
module flash_seq_checker #(
	parameter int unsigned T_X_US = 10,
	parameter int unsigned T_Y_US = 50,
	parameter int unsigned T_Z_LONG_US = 200,
	parameter int unsigned T_ZE_MS = 10,
	parameter int unsigned T_ALPHA_US = 10,
	parameter int unsigned T_GAMMA_US = 20,
	parameter int unsigned T_EPS_US = 2
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire flash_seq_pkg::dev_req_t dev_req_o,
	input wire logic write_enable_pin_o,
	input wire logic watchdog_timer_run_o
);
	import flash_seq_pkg::*;
	localparam int unsigned ZE = T_ZE_MS * US_PER_MS * CYC_PER_US;
	logic [6:0] img;
	logic [31:0] gap;
	logic [31:0] gap_any;
	logic [5:0] nb;
	logic [19:0] last_a;
	logic last_ff;
	logic ctl;
	logic wr;
	logic rd;
	logic vfy;
	logic [7:0] d;
	assign ctl = dev_req_o.valid && dev_req_o.kind == DEV_CTRL;
	assign wr = dev_req_o.valid && dev_req_o.kind == DEV_WRITE;
	assign rd = dev_req_o.valid && dev_req_o.kind == DEV_READ;
	assign vfy = img[FC_WRITE_VERIFY] || img[FC_CLEAR_VERIFY];
	assign d = dev_req_o.data[7:0];
	// ====
	// helper state
	// a low pin wipes the image, as it does in the device
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || !write_enable_pin_o) begin
			img <= '0;
		end else if (ctl) begin
			img <= d[6:0];
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			gap <= '0;
			gap_any <= '0;
			nb <= '0;
			last_a <= '0;
			last_ff <= 1'b0;
		end else begin
			gap <= ctl ? 32'h1 : gap + 32'h1;
			gap_any <= dev_req_o.valid ? 32'h1 : gap_any + 32'h1;
			nb <= ctl ? 6'h0 : nb + 6'(wr && nb != 6'h3f);
			if (dev_req_o.valid) begin
				last_a <= dev_req_o.addr;
				last_ff <= wr && d == FILL_BYTE;
			end
		end
	end
	// ====
	// assertions
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);
	group_whole_a: assert property (
		ctl && d[FC_WRITE_SETUP] && !img[FC_WRITE_SETUP] |-> nb == 6'd32)
		else $error("program group is not 32 byte writes");
	group_align_a: assert property (
		wr && nb == 6'h0 |-> dev_req_o.addr[4:0] == 5'h0)
		else $error("byte group off a 32 byte boundary");
	enable_wait_a: assert property (
		(wr && nb == 6'h0 && !vfy) || (dev_req_o.valid &&
		dev_req_o.kind == DEV_BLOCK) |-> gap >= T_X_US * CYC_PER_US)
		else $error("data or block select too soon");
	guard_run_a: assert property (
		ctl && (d[FC_WRITE_SETUP] || d[FC_CLEAR_SETUP])
		|-> watchdog_timer_run_o)
		else $error("setup without watchdog running");
	setup_first_a: assert property (
		ctl && (d[FC_WRITE] && !img[FC_WRITE] || d[FC_CLEAR] && !img[FC_CLEAR])
		|-> (img[FC_WRITE_SETUP] || img[FC_CLEAR_SETUP])
		&& gap >= T_Y_US * CYC_PER_US)
		else $error("pulse bit set without settled setup");
	pulse_len_a: assert property (
		img[FC_WRITE] |-> gap <= T_Z_LONG_US * CYC_PER_US + 2)
		else $error("program pulse too long");
	erase_len_a: assert property (
		img[FC_CLEAR] |-> gap <= ZE + 2)
		else $error("erase pulse too long");
	setup_off_a: assert property (
		ctl && (img[FC_WRITE_SETUP] && !d[FC_WRITE_SETUP]
		|| img[FC_CLEAR_SETUP] && !d[FC_CLEAR_SETUP])
		|-> gap >= T_ALPHA_US * CYC_PER_US ##[1:4] !watchdog_timer_run_o)
		else $error("setup cleared too soon or watchdog left running");
	verify_wait_a: assert property (
		wr && nb == 6'h0 && vfy |-> gap >= T_GAMMA_US * CYC_PER_US)
		else $error("dummy write too soon after verify entry");
	verify_read_a: assert property (
		rd |-> vfy && !img[FC_WRITE] && !img[FC_CLEAR] && last_ff &&
		last_a == dev_req_o.addr && gap_any >= T_EPS_US * CYC_PER_US)
		else $error("read without verify mode or dummy write");
	pin_gate_a: assert property (
		ctl && (d[FC_WRITE] || d[FC_CLEAR]) |-> write_enable_pin_o)
		else $error("pulse bit set with the pin low");
	prog_pulse_c: cover property (ctl && d[FC_WRITE]);
	erase_pulse_c: cover property (ctl && d[FC_CLEAR]);
	erase_read_c: cover property (rd && img[FC_CLEAR_VERIFY]);
endmodule : flash_seq_checker

bind flash_program_erase_sequencer flash_seq_checker #(
	.T_X_US(T_X_US),
	.T_Y_US(T_Y_US),
	.T_Z_LONG_US(T_Z_LONG_US),
	.T_ZE_MS(T_ZE_MS),
	.T_ALPHA_US(T_ALPHA_US),
	.T_GAMMA_US(T_GAMMA_US),
	.T_EPS_US(T_EPS_US)
) chk (
	.clk_sys_i(clk_sys_i),
	.sys_rst_i(sys_rst_i),
	.dev_req_o(dev_req_o),
	.write_enable_pin_o(write_enable_pin_o),
	.watchdog_timer_run_o(watchdog_timer_run_o)
);

/* flash_dev_model.sv */
// behavioural flash: control image, 32 byte latch, verify reads
// assumes one request per valid cycle; knobs are set by the bench
`timescale 1ns/1ns
module flash_dev_model (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire flash_seq_pkg::dev_req_t dev_req_i,
	input wire logic write_enable_pin_i,
	output logic dev_rvalid_o,
	output logic [15:0] dev_rdata_o
);
	import flash_seq_pkg::*;
	logic [7:0] mem [0:255];
	logic [7:0] latch [0:31];
	logic [2:0] grp = '0;
	logic [6:0] img = '0;
	logic [7:0] blk = '0;
	logic [7:0] va = '0;
	logic [15:0] word = '0;
	logic [7:0] d;
	int prog_fail = 0;
	int erase_fail = 0;
	int rd_lat = 1;
	int wait_cnt = 0;
	assign d = dev_req_i.data[7:0];
	initial begin
		foreach (mem[i]) mem[i] = FILL_BYTE;
		dev_rvalid_o = 1'b0;
		dev_rdata_o = 16'h0;
	end
	// ====
	// request handling
	always @(posedge clk_sys_i) begin
		dev_rvalid_o <= 1'b0;
		dev_rdata_o <= ~dev_rdata_o;
		if (wait_cnt == 1) begin
			dev_rvalid_o <= 1'b1;
			dev_rdata_o <= word;
		end
		if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
		if (dev_req_i.valid && dev_req_i.kind == DEV_READ) begin
			wait_cnt <= rd_lat;
			word <= (img[FC_WRITE] || img[FC_CLEAR]) ? 16'h55aa :
				{mem[{va[7:1], 1'b0}], mem[{va[7:1], 1'b1}]};
		end
		if (sys_rst_i || !write_enable_pin_i) begin
			img <= '0;
			blk <= '0;
		end else if (dev_req_i.valid) begin
			case (dev_req_i.kind)
			DEV_CTRL: begin
				img <= d[6:0];
				if (d[FC_WRITE] && !img[FC_WRITE] && img[FC_WRITE_SETUP]) begin
					if (prog_fail > 0) prog_fail <= prog_fail - 1;
					else for (int i = 0; i < 32; i++)
						mem[{grp, i[4:0]}] <= mem[{grp, i[4:0]}] & latch[i];
				end
				if (d[FC_CLEAR] && !img[FC_CLEAR] && img[FC_CLEAR_SETUP]
						&& blk != 8'h0) begin
					if (erase_fail > 0) erase_fail <= erase_fail - 1;
					else foreach (mem[i]) mem[i] <= FILL_BYTE;
				end
			end
			DEV_BLOCK: blk <= d;
			DEV_WRITE: begin
				if (img[FC_WRITE_VERIFY] || img[FC_CLEAR_VERIFY]) begin
					va <= dev_req_i.addr[7:0];
				end else begin
					latch[dev_req_i.addr[4:0]] <= d;
					grp <= dev_req_i.addr[7:5];
				end
			end
			default: ;
			endcase
		end
	end
endmodule : flash_dev_model

/* flash_program_erase_sequencer_bench.sv */
// bench: software over AXI4-Lite against the behavioural flash
// assumes shortened time parameters and a three pass limit
`timescale 1ns/1ns
module flash_program_erase_sequencer_bench;
	import flash_seq_pkg::*;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	axil_req_t axi_req = '0;
	axil_rsp_t axi_rsp;
	dev_req_t dev_req;
	logic dev_rvalid;
	logic [15:0] dev_rdata;
	logic we_pin;
	logic wd_run;
	logic [31:0] rd;
	int errors = 0;
	int check_count = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	// only the x, erase pulse and eta waits, the short pulse count and the pass limit are cut; the rest keep their defaults
	flash_program_erase_sequencer #(.T_X_US(1), .LOOPS_SHORT(1),
		.T_ZE_MS(1), .T_ETA_US(1), .MAX_LOOPS(8'd3)) dut (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.axi_req_i(axi_req),
		.axi_rsp_o(axi_rsp),
		.dev_req_o(dev_req),
		.dev_rvalid_i(dev_rvalid),
		.dev_rdata_i(dev_rdata),
		.write_enable_pin_o(we_pin),
		.watchdog_timer_run_o(wd_run)
	);
	flash_dev_model mdl (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.dev_req_i(dev_req),
		.write_enable_pin_i(we_pin),
		.dev_rvalid_o(dev_rvalid),
		.dev_rdata_o(dev_rdata)
	);
	// ====
	// tasks
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic hang;
		errors++;
		$display("[ERR] handshake expected answer seen none");
		end_sim();
	endtask : hang
	// values seen at the falling edge are what the next rising edge samples
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic aw;
		logic w;
		logic b;
		@(posedge clk_sys_i);
		axi_req.awaddr <= a;
		axi_req.wdata <= v;
		axi_req.wstrb <= 4'hf;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(negedge clk_sys_i);
			aw = axi_rsp.awready;
			w = axi_rsp.wready;
			b = axi_rsp.bvalid;
			if (b) chk("write response", {30'h0, axi_rsp.bresp}, 32'h0);
			@(posedge clk_sys_i);
			if (aw) axi_req.awvalid <= 1'b0;
			if (w) axi_req.wvalid <= 1'b0;
			if (b) begin
				axi_req.bready <= 1'b0;
				return;
			end
		end
		hang();
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] v);
		logic ar;
		logic r;
		@(posedge clk_sys_i);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(negedge clk_sys_i);
			ar = axi_rsp.arready;
			r = axi_rsp.rvalid;
			v = axi_rsp.rdata;
			if (r) chk("read response", {30'h0, axi_rsp.rresp}, 32'h0);
			@(posedge clk_sys_i);
			if (ar) axi_req.arvalid <= 1'b0;
			if (r) begin
				axi_req.rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask : axr
	task automatic wait_idle;
		for (int n = 0; n < 20000; n++) begin
			axr(OFF_STATUS, rd);
			if (rd[STAT_BUSY] === 1'b0) return;
		end
		hang();
	endtask : wait_idle
	// start is only honoured once the pin bit is already set
	task automatic run_op(input logic erase);
		axw(OFF_CTRL, 32'h4);
		axw(OFF_CTRL, {29'h0, 1'b1, erase, 1'b1});
		wait_idle();
	endtask : run_op
	// ====
	// scenarios
	initial begin
		repeat (2) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		chk("pin after reset", {31'h0, we_pin}, 32'h0);
		axr(OFF_STATUS, rd);
		chk("status after reset", rd & 32'hffff, 32'h0);
		axr(OFF_DATA, rd);
		chk("data after reset", rd, 32'hffffffff);
		axw(8'h40, 32'hffffffff);
		axr(8'h40, rd);
		chk("unmapped read", rd, 32'h0);
		axw(OFF_CTRL, 32'h1);
		axr(OFF_STATUS, rd);
		chk("start without pin", rd & 32'h7, 32'h0);
		axw(OFF_ADDR, 32'h12345);
		axr(OFF_ADDR, rd);
		chk("group base", rd, 32'h12340);
		for (int k = 0; k < 8; k++)
			axw(OFF_DATA + 8'(4 * k), 32'h03020100 + 32'h04040404 * 32'(k));
		mdl.prog_fail = 3;
		run_op(1'b0);
		chk("fail at pass limit", rd & 32'h5, 32'h4);
		axw(OFF_STATUS, 32'h4);
		axr(OFF_STATUS, rd);
		chk("fail cleared", rd & 32'h4, 32'h0);
		mdl.prog_fail = 2;
		run_op(1'b0);
		chk("done on last pass", rd & 32'h7, 32'h2);
		for (int j = 0; j < 32; j++)
			chk("programmed byte", {24'h0, mdl.mem[8'h40 + 8'(j)]}, 32'(j));
		axw(OFF_CTRL, 32'h4);
		axw(OFF_CTRL, 32'h5);
		repeat (30) @(posedge clk_sys_i);
		axr(OFF_STATUS, rd);
		chk("busy mid run", rd & 32'h1, 32'h1);
		axw(OFF_CTRL, 32'h0);
		wait_idle();
		chk("abort on pin drop", rd & 32'h4, 32'h4);
		chk("pin dropped", {31'h0, we_pin}, 32'h0);
		axw(OFF_STATUS, 32'h6);
		axw(OFF_BLOCK, 32'h1);
		axw(OFF_ELEN, 32'h10);
		mdl.erase_fail = 1;
		mdl.rd_lat = 4;
		run_op(1'b1);
		chk("erase done", rd & 32'h7, 32'h2);
		for (int j = 0; j < 32; j++)
			chk("erased byte", {24'h0, mdl.mem[8'h40 + 8'(j)]}, 32'hff);
		end_sim();
	end
endmodule : flash_program_erase_sequencer_bench
